/* File: rtl/bmsc_core.sv */
// Purpose: executes program-to-data block move, accumulator right barrel shift and computed calls
// Assumes: program memory read data is valid in the same cycle as pm_rd_o
// Notes: wait-state counts come in per request; same-block conflicts are flagged by the decoder
// Summary of operation
// - register-sourced single move takes two cycles
// - register-sourced repeated move: n words, n+1 cycles
// - immediate-sourced single move takes three cycles
// - immediate-sourced repeated move takes n+2 cycles
// - destination sharing code block adds a cycle, two when repeated
// - register-sourced source/destination same block repeat takes 2n-1
// - shift accumulator right 1..16, one cycle
// - fill high bits with zero or sign
// - call pushes pc+1, loads pc from accumulator
// - taken call costs four cycles, discards prefetch
// - computed call refused under repeat
// - delayed call pushes pc plus three
// - delayed call runs two slot words first
// - delayed call takes two cycles, not repeatable
// - repeated move source address increments per word
// - interrupts held off during repeated move
// - repeat moves count plus one words
`timescale 1ns/10ps
module bmsc_core
   import bmsc_pkg::*;
(
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic start_i,
   input wire bmsc_op_t op_i,
   input wire logic repeat_i,
   input wire logic [15:0] repeat_count_reg_i,
   input wire logic imm_src_i,
   input wire logic [BMSC_AW-1:0] long_imm_i,
   input wire logic [BMSC_AW-1:0] block_move_address_reg_i,
   input wire logic [BMSC_AW-1:0] dst_addr_i,
   input wire logic same_blk_dst_code_i,
   input wire logic same_blk_src_dst_i,
   input wire logic [BMSC_WS_W-1:0] code_ws_i,
   input wire logic [BMSC_WS_W-1:0] src_ws_i,
   input wire logic [BMSC_WS_W-1:0] dst_ws_i,
   input wire logic [BMSC_ACC_W-1:0] accumulator_reg_i,
   input wire logic sign_extension_mode_bit_i,
   input wire logic [BMSC_SHC_W-1:0] shift_code_i,
   input wire logic [BMSC_AW-1:0] pc_i,
   input wire logic [15:0] pm_rdata_i,
   output logic busy_o,
   output logic done_o,
   output logic illegal_o,
   output logic int_hold_o,
   output logic pm_rd_o,
   output logic [BMSC_AW-1:0] pm_addr_o,
   output logic dm_wr_o,
   output logic [BMSC_AW-1:0] dm_addr_o,
   output logic [15:0] dm_wdata_o,
   output logic acc_wr_o,
   output logic [BMSC_ACC_W-1:0] acc_wdata_o,
   output logic stack_push_o,
   output logic [BMSC_AW-1:0] stack_top_o,
   output logic pc_load_o,
   output logic [BMSC_AW-1:0] pc_target_o,
   output logic fetch_flush_o,
   output logic delay_slot_o
);

   typedef struct packed {
      bmsc_state_t state;
      logic [BMSC_CNT_W-1:0] cnt;
      logic [BMSC_CNT_W-1:0] total;
      logic [BMSC_CNT_W-1:0] gap;
      logic [BMSC_CNT_W-1:0] base;
      logic [BMSC_WRD_W-1:0] left;
      logic first;
      logic sd_conf;
      logic busy;
      logic done;
      logic illegal;
      logic int_hold;
      logic pm_rd;
      logic dm_wr;
      logic acc_wr;
      logic stack_push;
      logic pc_load;
      logic flush;
      logic delay_slot;
      logic [BMSC_AW-1:0] pm_addr;
      logic [BMSC_AW-1:0] dm_addr;
      logic [15:0] wdata;
      logic [BMSC_AW-1:0] stack_top;
      logic [BMSC_AW-1:0] pc_target;
      logic [BMSC_ACC_W-1:0] acc_wdata;
   } bmsc_core_st_t;

   bmsc_core_st_t cur_ff;
   bmsc_core_st_t nxt_st;
   logic [BMSC_ACC_W-1:0] shift_res;
   logic [BMSC_WRD_W-1:0] n_words;
   logic [BMSC_CNT_W-1:0] hdr;
   logic [BMSC_CNT_W-1:0] extra;

   // cycles before the first source read: code fetch words and their wait states
   function automatic logic [BMSC_CNT_W-1:0] move_hdr(input logic imm, input logic rep, input logic dc,
                                                      input logic [BMSC_WS_W-1:0] cws);
      logic [BMSC_CNT_W-1:0] fetch;
      fetch = imm ? BMSC_HDR_IMM : BMSC_HDR_REG;
      move_hdr = fetch + BMSC_CNT_W'(fetch * {20'h00000, cws});
      if (dc) begin
         move_hdr = move_hdr + (rep ? BMSC_DC_REP : BMSC_DC_SGL);
      end
   endfunction : move_hdr

   // whole move duration from header, word count and per-word slot
   function automatic logic [BMSC_CNT_W-1:0] move_total(input logic [BMSC_CNT_W-1:0] h,
                                                        input logic [BMSC_WRD_W-1:0] n,
                                                        input logic [BMSC_CNT_W-1:0] b, input logic sd);
      logic [BMSC_CNT_W-1:0] nw;
      nw = {7'h00, n};
      move_total = h + BMSC_CNT_W'(nw * b);
      if (sd) begin
         move_total = move_total + nw - BMSC_SD_OFS;
      end
   endfunction : move_total

   bmsc_shifter u_shift (
      .acc_i(accumulator_reg_i),
      .sign_extension_mode_bit_i(sign_extension_mode_bit_i),
      .code_i(shift_code_i),
      .res_o(shift_res)
   );

   // next-state logic; every pulse output defaults low each cycle
   always_comb begin
      n_words = repeat_i ? ({1'b0, repeat_count_reg_i} + 17'h00001) : 17'h00001;
      hdr = move_hdr(imm_src_i, repeat_i, same_blk_dst_code_i, code_ws_i);
      extra = (cur_ff.sd_conf && !cur_ff.first) ? 24'h000001 : 24'h000000;
      nxt_st = cur_ff;
      nxt_st.done = 1'b0;
      nxt_st.illegal = 1'b0;
      nxt_st.pm_rd = 1'b0;
      nxt_st.dm_wr = 1'b0;
      nxt_st.acc_wr = 1'b0;
      nxt_st.stack_push = 1'b0;
      nxt_st.pc_load = 1'b0;
      nxt_st.flush = 1'b0;
      case (cur_ff.state)
         BMSC_S_IDLE: begin
            if (start_i) begin
               case (op_i)
                  BMSC_OP_MOVE: begin
                     nxt_st.state = BMSC_S_MOVE;
                     nxt_st.busy = 1'b1;
                     nxt_st.int_hold = repeat_i;
                     nxt_st.cnt = BMSC_CNT_RST;
                     nxt_st.base = BMSC_XFER_CYC + {20'h00000, src_ws_i} + {20'h00000, dst_ws_i};
                     nxt_st.sd_conf = repeat_i && same_blk_src_dst_i && (n_words > 17'h00001);
                     nxt_st.total = move_total(hdr, n_words,
                                               BMSC_XFER_CYC + {20'h00000, src_ws_i} + {20'h00000, dst_ws_i},
                                               repeat_i && same_blk_src_dst_i && (n_words > 17'h00001));
                     nxt_st.gap = hdr - 24'h000001;
                     nxt_st.left = n_words;
                     nxt_st.first = 1'b1;
                     nxt_st.pm_rd = (hdr == 24'h000001);
                     nxt_st.pm_addr = imm_src_i ? long_imm_i : block_move_address_reg_i;
                     nxt_st.dm_addr = dst_addr_i;
                  end
                  BMSC_OP_SHIFT: begin
                     nxt_st.acc_wr = 1'b1;
                     nxt_st.acc_wdata = shift_res;
                     nxt_st.done = 1'b1;
                  end
                  BMSC_OP_CALL, BMSC_OP_DCALL: begin
                     if (repeat_i) begin
                        // a repeated call is dropped whole: no push, no jump
                        nxt_st.illegal = 1'b1;
                        nxt_st.done = 1'b1;
                     end else begin
                        nxt_st.state = BMSC_S_CALL;
                        nxt_st.busy = 1'b1;
                        nxt_st.cnt = BMSC_CNT_RST;
                        nxt_st.stack_push = 1'b1;
                        nxt_st.pc_target = accumulator_reg_i[15:0];
                        if (op_i == BMSC_OP_CALL) begin
                           nxt_st.stack_top = pc_i + BMSC_CALL_RET_INC;
                           nxt_st.total = BMSC_CALL_CYC + BMSC_CNT_W'(BMSC_CALL_WS_MUL * {20'h00000, code_ws_i});
                           nxt_st.delay_slot = 1'b0;
                        end else begin
                           nxt_st.stack_top = pc_i + BMSC_DCALL_RET_INC;
                           nxt_st.total = BMSC_DCALL_CYC + BMSC_CNT_W'(BMSC_DCALL_WS_MUL * {20'h00000, code_ws_i});
                           nxt_st.delay_slot = 1'b1;
                        end
                     end
                  end
                  default: begin
                  end
               endcase
            end
         end
         BMSC_S_MOVE: begin
            nxt_st.cnt = cur_ff.cnt + 24'h000001;
            // source word read this cycle is written to data memory next cycle
            if (cur_ff.pm_rd) begin
               nxt_st.dm_wr = 1'b1;
               nxt_st.wdata = pm_rdata_i;
               nxt_st.pm_addr = cur_ff.pm_addr + 16'h0001;
               nxt_st.left = cur_ff.left - 17'h00001;
               nxt_st.first = 1'b0;
               nxt_st.gap = cur_ff.base + extra - 24'h000001;
            end else if (cur_ff.gap != BMSC_CNT_RST) begin
               nxt_st.gap = cur_ff.gap - 24'h000001;
            end
            if (cur_ff.dm_wr) begin
               nxt_st.dm_addr = cur_ff.dm_addr + 16'h0001;
            end
            nxt_st.pm_rd = (nxt_st.gap == BMSC_CNT_RST) && (nxt_st.left != 17'h00000);
            // finish only after the full time and the last word, whichever is later
            if ((cur_ff.cnt >= cur_ff.total - 24'h000001) && (cur_ff.left == 17'h00000) && !cur_ff.pm_rd) begin
               nxt_st.state = BMSC_S_IDLE;
               nxt_st.busy = 1'b0;
               nxt_st.int_hold = 1'b0;
               nxt_st.done = 1'b1;
            end
         end
         BMSC_S_CALL: begin
            nxt_st.cnt = cur_ff.cnt + 24'h000001;
            if (cur_ff.cnt >= cur_ff.total - 24'h000001) begin
               nxt_st.state = BMSC_S_IDLE;
               nxt_st.busy = 1'b0;
               nxt_st.done = 1'b1;
               nxt_st.pc_load = 1'b1;
               nxt_st.flush = !cur_ff.delay_slot;
               nxt_st.delay_slot = 1'b0;
            end
         end
         default: begin
            nxt_st.state = BMSC_S_IDLE;
         end
      endcase
   end

   // single state register; reset clears every control flag and output
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         cur_ff <= '{state: BMSC_S_IDLE, cnt: BMSC_CNT_RST, total: BMSC_CNT_RST, gap: BMSC_CNT_RST,
                     base: BMSC_CNT_RST, left: 17'h00000, pm_addr: BMSC_ADDR_RST, dm_addr: BMSC_ADDR_RST,
                     wdata: BMSC_ADDR_RST, stack_top: BMSC_ADDR_RST, pc_target: BMSC_ADDR_RST,
                     acc_wdata: BMSC_ACC_RST, default: 1'b0};
      end else begin
         cur_ff <= nxt_st;
      end
   end

   assign busy_o = cur_ff.busy;
   assign done_o = cur_ff.done;
   assign illegal_o = cur_ff.illegal;
   assign int_hold_o = cur_ff.int_hold;
   assign pm_rd_o = cur_ff.pm_rd;
   assign pm_addr_o = cur_ff.pm_addr;
   assign dm_wr_o = cur_ff.dm_wr;
   assign dm_addr_o = cur_ff.dm_addr;
   assign dm_wdata_o = cur_ff.wdata;
   assign acc_wr_o = cur_ff.acc_wr;
   assign acc_wdata_o = cur_ff.acc_wdata;
   assign stack_push_o = cur_ff.stack_push;
   assign stack_top_o = cur_ff.stack_top;
   assign pc_load_o = cur_ff.pc_load;
   assign pc_target_o = cur_ff.pc_target;
   assign fetch_flush_o = cur_ff.flush;
   assign delay_slot_o = cur_ff.delay_slot;

   // checking helpers: busy length, words written, expected length of plain on-chip moves
   logic [BMSC_CNT_W-1:0] chk_busy_ff;
   logic [BMSC_WRD_W-1:0] chk_wr_ff;
   logic [BMSC_WRD_W-1:0] chk_n_ff;
   logic [BMSC_CNT_W-1:0] chk_exp_ff;
   logic chk_on_ff;
   logic chk_mv_ff;
   logic [BMSC_AW-1:0] chk_last_rd_ff;
   logic chk_rd_seen_ff;
   logic mv_go;
   logic plain;

   assign mv_go = start_i && (op_i == BMSC_OP_MOVE) && (cur_ff.state == BMSC_S_IDLE);
   assign plain = (code_ws_i == 4'h0) && (src_ws_i == 4'h0) && (dst_ws_i == 4'h0) && !same_blk_dst_code_i;

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         chk_busy_ff <= BMSC_CNT_RST;
         chk_wr_ff <= 17'h00000;
         chk_n_ff <= 17'h00000;
         chk_exp_ff <= BMSC_CNT_RST;
         chk_on_ff <= 1'b0;
         chk_mv_ff <= 1'b0;
         chk_last_rd_ff <= BMSC_ADDR_RST;
         chk_rd_seen_ff <= 1'b0;
      end else if (mv_go) begin
         chk_busy_ff <= BMSC_CNT_RST;
         chk_wr_ff <= 17'h00000;
         chk_n_ff <= n_words;
         chk_mv_ff <= 1'b1;
         chk_rd_seen_ff <= 1'b0;
         chk_on_ff <= plain && !(same_blk_src_dst_i && imm_src_i && repeat_i);
         if (same_blk_src_dst_i && repeat_i && (n_words > 17'h00001)) begin
            chk_exp_ff <= {6'h00, n_words, 1'b0} - 24'h000001;
         end else begin
            chk_exp_ff <= {7'h00, n_words} + (imm_src_i ? 24'h000002 : 24'h000001);
         end
      end else begin
         chk_busy_ff <= chk_busy_ff + (busy_o ? 24'h000001 : 24'h000000);
         chk_wr_ff <= chk_wr_ff + (dm_wr_o ? 17'h00001 : 17'h00000);
         if (pm_rd_o) begin
            chk_last_rd_ff <= pm_addr_o;
            chk_rd_seen_ff <= 1'b1;
         end
         if (start_i && (cur_ff.state == BMSC_S_IDLE)) begin
            chk_mv_ff <= 1'b0;
         end
      end
   end

   move_len_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      done_o && chk_mv_ff && chk_on_ff |-> chk_busy_ff == chk_exp_ff)
      else $error("block move length differs from expected cycle count");
   dst_code_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      mv_go && plain == 1'b0 && same_blk_dst_code_i && !repeat_i && !imm_src_i && code_ws_i == 4'h0 &&
      src_ws_i == 4'h0 && dst_ws_i == 4'h0 |-> ##4 done_o)
      else $error("destination sharing code block did not add one cycle");
   word_count_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      done_o && chk_mv_ff |-> chk_wr_ff == chk_n_ff)
      else $error("moved word count is not repeat count plus one");
   src_inc_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      pm_rd_o && chk_rd_seen_ff && busy_o |-> pm_addr_o == chk_last_rd_ff + 16'h0001)
      else $error("source address did not advance by one");
   int_hold_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      mv_go && repeat_i |=> int_hold_o throughout (busy_o [*2]))
      else $error("interrupts not held during repeated move");
   shift_one_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      start_i && op_i == BMSC_OP_SHIFT && cur_ff.state == BMSC_S_IDLE |=> acc_wr_o && done_o && !busy_o)
      else $error("barrel shift did not finish in one cycle");
   shift_fill_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      start_i && op_i == BMSC_OP_SHIFT && cur_ff.state == BMSC_S_IDLE
      |=> acc_wdata_o[31] == ($past(sign_extension_mode_bit_i) & $past(accumulator_reg_i[31])))
      else $error("barrel shift fill bits wrong for sign mode");
   call_push_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      start_i && op_i == BMSC_OP_CALL && !repeat_i && cur_ff.state == BMSC_S_IDLE
      |=> stack_push_o && stack_top_o == $past(pc_i) + 16'h0001 && pc_target_o == $past(accumulator_reg_i[15:0]))
      else $error("computed call pushed or targeted the wrong value");
   call_cost_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      start_i && op_i == BMSC_OP_CALL && !repeat_i && code_ws_i == 4'h0 && cur_ff.state == BMSC_S_IDLE
      |=> !pc_load_o [*4] ##1 (pc_load_o && fetch_flush_o))
      else $error("computed call did not take four cycles");
   no_repeat_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      start_i && (op_i == BMSC_OP_CALL || op_i == BMSC_OP_DCALL) && repeat_i && cur_ff.state == BMSC_S_IDLE
      |=> illegal_o && !stack_push_o ##1 !busy_o && !pc_load_o)
      else $error("repeated computed call was not refused");
   dcall_push_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      start_i && op_i == BMSC_OP_DCALL && !repeat_i && cur_ff.state == BMSC_S_IDLE
      |=> stack_push_o && stack_top_o == $past(pc_i) + 16'h0003)
      else $error("delayed call pushed the wrong return address");
   dcall_slot_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      start_i && op_i == BMSC_OP_DCALL && !repeat_i && code_ws_i == 4'h0 && cur_ff.state == BMSC_S_IDLE
      |=> delay_slot_o [*2] ##1 (pc_load_o && !fetch_flush_o && !delay_slot_o))
      else $error("delayed call slot window or length wrong");

   rep_move_c: cover property (@(posedge clk_i) disable iff (sys_rst_i) done_o && chk_mv_ff && chk_n_ff > 17'h00002);
   call_c: cover property (@(posedge clk_i) disable iff (sys_rst_i) pc_load_o && fetch_flush_o);
   dcall_c: cover property (@(posedge clk_i) disable iff (sys_rst_i) pc_load_o && !fetch_flush_o);
   refuse_c: cover property (@(posedge clk_i) disable iff (sys_rst_i) illegal_o);
   zero_fill_c: cover property (@(posedge clk_i) disable iff (sys_rst_i)
      start_i && op_i == BMSC_OP_SHIFT && !sign_extension_mode_bit_i && accumulator_reg_i[31]);

endmodule : bmsc_core

/* File: rtl/bmsc_pkg.sv */
// Purpose: shared constants and types for the block move, barrel shift and computed call executor
// Assumes: one core clock, decoded instructions arrive as single-cycle start requests
// Notes: cycle figures are for conflict-free on-chip code and operands, wait states add on top
package bmsc_pkg;

   // widths
   localparam int BMSC_AW = 16;
   localparam int BMSC_ACC_W = 32;
   localparam int BMSC_CNT_W = 24;
   localparam int BMSC_WS_W = 4;
   localparam int BMSC_SHC_W = 4;
   localparam int BMSC_WRD_W = 17;

   // return address offsets pushed to the stack top
   localparam logic [15:0] BMSC_CALL_RET_INC = 16'h0001;
   localparam logic [15:0] BMSC_DCALL_RET_INC = 16'h0003;

   // call timing in cycles and wait-state multipliers per code fetch
   localparam logic [23:0] BMSC_CALL_CYC = 24'h000004;
   localparam logic [23:0] BMSC_DCALL_CYC = 24'h000002;
   localparam logic [23:0] BMSC_CALL_WS_MUL = 24'h000003;
   localparam logic [23:0] BMSC_DCALL_WS_MUL = 24'h000001;

   // block move timing in cycles
   localparam logic [23:0] BMSC_HDR_REG = 24'h000001;
   localparam logic [23:0] BMSC_HDR_IMM = 24'h000002;
   localparam logic [23:0] BMSC_DC_SGL = 24'h000001;
   localparam logic [23:0] BMSC_DC_REP = 24'h000002;
   localparam logic [23:0] BMSC_XFER_CYC = 24'h000001;
   localparam logic [23:0] BMSC_SD_OFS = 24'h000002;

   // reset values
   localparam logic [15:0] BMSC_ADDR_RST = 16'h0000;
   localparam logic [31:0] BMSC_ACC_RST = 32'h00000000;
   localparam logic [23:0] BMSC_CNT_RST = 24'h000000;

   typedef enum logic [2:0] {
      BMSC_OP_NONE  = 3'h0,
      BMSC_OP_MOVE  = 3'h1,
      BMSC_OP_SHIFT = 3'h2,
      BMSC_OP_CALL  = 3'h3,
      BMSC_OP_DCALL = 3'h4
   } bmsc_op_t;

   // gray along idle -> move and idle -> call
   typedef enum logic [1:0] {
      BMSC_S_IDLE = 2'h0,
      BMSC_S_MOVE = 2'h1,
      BMSC_S_CALL = 2'h2
   } bmsc_state_t;

endpackage : bmsc_pkg

/* File: rtl/bmsc_shifter.sv */
// Purpose: accumulator right barrel shift by 1 to 16 positions
// Assumes: shift code k selects a shift of k+1
// Notes: purely combinational, the caller registers the result
`timescale 1ns/10ps
module bmsc_shifter
   import bmsc_pkg::*;
(
   input wire logic [BMSC_ACC_W-1:0] acc_i,
   input wire logic sign_extension_mode_bit_i,
   input wire logic [BMSC_SHC_W-1:0] code_i,
   output logic [BMSC_ACC_W-1:0] res_o
);

   logic [4:0] amount;

   // code 0 means one place, code 15 means sixteen places
   assign amount = {1'b0, code_i} + 5'h01;

   // vacated high bits take zero or copies of the sign
   always_comb begin
      if (sign_extension_mode_bit_i) begin
         res_o = BMSC_ACC_W'($signed(acc_i) >>> amount);
      end else begin
         res_o = acc_i >> amount;
      end
   end

endmodule : bmsc_shifter

/* File: sim/bmsc_pm_model.sv */
// Purpose: program memory model answering the source reads of the block move
// Assumes: read data is valid in the same cycle as the read strobe
// Notes: each word is its address xor a fixed mask, so the bench can predict it
`timescale 1ns/10ps
module bmsc_pm_model
   import bmsc_pkg::*;
(
   input wire logic clk_i,
   input wire logic pm_rd_i,
   input wire logic [BMSC_AW-1:0] pm_addr_i,
   output logic [15:0] pm_rdata_o
);
   logic [15:0] last_ff = 16'h0000;
   // outside a read the bus shows the inverse of the last word, so stale data is caught
   assign pm_rdata_o = pm_rd_i ? (pm_addr_i ^ 16'h5a5a) : ~last_ff;
   // remember the last word handed out
   always_ff @(posedge clk_i) begin
      if (pm_rd_i) begin
         last_ff <= pm_rdata_o;
      end
   end
endmodule : bmsc_pm_model

/* File: sim/block_move_shift_call_exec_tb.sv */
// Purpose: self-checking bench for the block move, barrel shift and computed call executor
// Assumes: one instruction in flight, next start after the done cycle
// Notes: a table of corner cases runs first, then random instructions from an lfsr
`timescale 1ns/10ps
module block_move_shift_call_exec_tb
   import bmsc_pkg::*;
;
   logic clk = 1'b0, rst = 1'b1, start, rep, imm, dcc, sd, sgn_ext;
   bmsc_op_t op;
   logic [15:0] cnt, limm, bm_src, dst, pc, rdata, pma, dma, dmd, stk_top, pct;
   logic [3:0] cws, sws, dws, shc;
   logic [31:0] acc, accd, lfsr_ff;
   logic busy, done, ill, ihold, pmrd, dmwr, accwr, push, pcld, flush, dslot;
   int miscompares = 0, total_checks = 0, cyc_ff = 0;
   logic [15:0] cases [19] = '{16'h2000, 16'h3020, 16'h3000, 16'h2800, 16'h3830, 16'h2400, 16'h3420,
      16'h3240, 16'h3a40, 16'h3012, 16'h2803, 16'h41f0, 16'h4000, 16'h5130, 16'h6000, 16'h6002,
      16'h7000, 16'h8001, 16'h9000};

   bmsc_core i_bmsc_core (.clk_i(clk), .sys_rst_i(rst), .start_i(start), .op_i(op), .repeat_i(rep),
      .repeat_count_reg_i(cnt), .imm_src_i(imm), .long_imm_i(limm), .block_move_address_reg_i(bm_src),
      .dst_addr_i(dst), .same_blk_dst_code_i(dcc), .same_blk_src_dst_i(sd), .code_ws_i(cws),
      .src_ws_i(sws), .dst_ws_i(dws), .accumulator_reg_i(acc), .sign_extension_mode_bit_i(sgn_ext),
      .shift_code_i(shc), .pc_i(pc), .pm_rdata_i(rdata), .busy_o(busy), .done_o(done),
      .illegal_o(ill), .int_hold_o(ihold), .pm_rd_o(pmrd), .pm_addr_o(pma), .dm_wr_o(dmwr),
      .dm_addr_o(dma), .dm_wdata_o(dmd), .acc_wr_o(accwr), .acc_wdata_o(accd), .stack_push_o(push),
      .stack_top_o(stk_top), .pc_load_o(pcld), .pc_target_o(pct), .fetch_flush_o(flush),
      .delay_slot_o(dslot));
   bmsc_pm_model i_bmsc_pm_model (.clk_i(clk), .pm_rd_i(pmrd), .pm_addr_i(pma), .pm_rdata_o(rdata));

   // 40 MHz core clock
   always #12.5 clk = ~clk;

   function automatic logic [31:0] nxt_rand(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : nxt_rand

   // expected busy length; zero for shift and for a refused call
   function automatic int exp_t();
      int n, h, b;
      n = rep ? cnt + 1 : 1;
      h = (imm ? 2 : 1) * (1 + cws) + (dcc ? (rep ? 2 : 1) : 0);
      b = 1 + sws + dws;
      case (op)
         BMSC_OP_MOVE: return h + n * b + ((rep && sd && n >= 2) ? n - 2 : 0);
         BMSC_OP_CALL: return rep ? 0 : 4 + 3 * cws;
         BMSC_OP_DCALL: return rep ? 0 : 2 + cws;
         default: return 0;
      endcase
   endfunction : exp_t

   // 32-bit arithmetic so a code of 15 shifts by 16, not by 0
   function automatic logic [31:0] exp_shift();
      return sgn_ext ? 32'($signed(acc) >>> (32'(shc) + 1)) : acc >> (32'(shc) + 1);
   endfunction : exp_shift

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : tally_and_finish

   // issue one instruction and follow it cycle by cycle until its done pulse
   task automatic exec(input logic [15:0] e);
      int t, k, r, w;
      logic cl;
      r = 0;
      w = 0;
      lfsr_ff = nxt_rand(lfsr_ff);
      @(posedge clk);
      op <= bmsc_op_t'(e[15:13]);
      {rep, imm, dcc, sd, sgn_ext} <= e[12:8];
      cnt <= {12'h000, e[7:4]};
      shc <= e[7:4];
      {cws, sws, dws} <= {3{e[3:0]}};
      {limm, bm_src} <= lfsr_ff;
      dst <= lfsr_ff[23:8];
      pc <= lfsr_ff[27:12];
      acc <= lfsr_ff; // sign apart from fill mode, so zero fill of a negative value is reached
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      t = exp_t();
      cl = (op == BMSC_OP_CALL) || (op == BMSC_OP_DCALL);
      for (k = 0; k <= t; k++) begin
         #1;
         chk("busy", k < t, busy);
         chk("done", k == t, done);
         chk("illegal", cl && rep && k == 0, ill);
         chk("int_hold", op == BMSC_OP_MOVE && rep && k < t, ihold);
         chk("stack_push", cl && !rep && k == 0, push);
         chk("pc_load", cl && !rep && k == t, pcld);
         chk("fetch_flush", op == BMSC_OP_CALL && !rep && k == t, flush);
         chk("delay_slot", op == BMSC_OP_DCALL && k < t, dslot);
         chk("acc_wr", op == BMSC_OP_SHIFT && k == 0, accwr);
         if (op == BMSC_OP_SHIFT) chk("acc_wdata", exp_shift(), accd);
         if (cl && !rep && k == 0) begin
            chk("stack_top", pc + (op == BMSC_OP_CALL ? 16'h0001 : 16'h0003), stk_top);
         end
         if (cl && !rep && k == t) chk("pc_target", acc[15:0], pct);
         if (pmrd === 1'b1) begin
            chk("pm_addr", 16'((imm ? limm : bm_src) + r), pma);
            r++;
         end
         if (dmwr === 1'b1) begin
            chk("dm_addr", 16'(dst + w), dma);
            chk("dm_wdata", 16'((imm ? limm : bm_src) + w) ^ 16'h5a5a, dmd);
            w++;
         end
         if (k < t) @(posedge clk);
      end
      if (op == BMSC_OP_MOVE) chk("words", rep ? cnt + 1 : 1, w);
      // an unknown read strobe would skip the address check, so the reads are counted too
      if (op == BMSC_OP_MOVE) chk("reads", rep ? cnt + 1 : 1, r);
   endtask : exec

   // a hang is cut short and counted as a mismatch
   always @(posedge clk) begin
      cyc_ff <= cyc_ff + 1;
      if (cyc_ff == 30000) begin
         miscompares++;
         tally_and_finish();
      end
   end

   // reset, corner table, then random instructions
   initial begin
      {start, rep, imm, dcc, sd, sgn_ext} = '0;
      op = BMSC_OP_NONE;
      {cnt, limm, bm_src, dst, pc, cws, sws, dws, shc, acc} = '0;
      lfsr_ff = 32'had533e61;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      foreach (cases[i]) exec(cases[i]);
      repeat (80) begin
         lfsr_ff = nxt_rand(lfsr_ff);
         exec({3'(lfsr_ff[17:16] + 2'h1), lfsr_ff[12:4], 2'h0, lfsr_ff[1:0]});
      end
      tally_and_finish();
   end
endmodule : block_move_shift_call_exec_tb
